// *** include/flow_i2c_if.sv ***
// Open-drain two-wire bus joining the master and the sensor end.
`timescale 1ns/1ps
interface flow_i2c_if;
   logic scl_m_oe;
   logic sda_m_oe;
   logic sda_s_oe;
   logic scl_m_o;
   logic sda_m_o;
   logic sda_s_o;
   // Pull-ups make the wires high unless some party drives low.
   wire scl = !(scl_m_oe && !scl_m_o);
   wire sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
   modport master (output scl_m_oe, output scl_m_o, output sda_m_oe, output sda_m_o, input scl, input sda);
   modport sensor (output sda_s_oe, output sda_s_o, input scl, input sda);
endinterface : flow_i2c_if

// *** include/flow_i2c_pkg.sv ***
// Shared constants for the flow sensor two-wire link.
package flow_i2c_pkg;
   localparam logic [6:0] SLAVE_ADDR = 7'h50;
   localparam logic READ_BIT = 1'b1;
   localparam logic ACK_LEVEL = 1'b0;
   localparam logic NACK_LEVEL = 1'b1;
   localparam int BITS_PER_BYTE = 8;
   localparam int FLOW_WIDTH = 12;
   localparam int FRAME_BYTES = 5;
   localparam int CLK_HZ = 100_000_000;
   localparam int SCL_STD_HZ = 100_000;
   localparam int SCL_FAST_HZ = 400_000;
   // One bus bit is four quarter phases of the divided clock.
   localparam int QUARTERS_PER_BIT = 4;
   localparam int QTR_STD = CLK_HZ / (SCL_STD_HZ * QUARTERS_PER_BIT);
   localparam int QTR_FAST = CLK_HZ / (SCL_FAST_HZ * QUARTERS_PER_BIT);
   localparam logic [3:0] FLOW_HIGH_PAD = 4'h0;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [2:0] IDX_CHECKSUM = 3'h0;
   localparam logic [2:0] IDX_FLOW_HIGH = 3'h1;
   localparam logic [2:0] IDX_FLOW_LOW = 3'h2;
   localparam logic [2:0] IDX_REP_HIGH = 3'h3;
   localparam logic [2:0] IDX_REP_LOW = 3'h4;
endpackage : flow_i2c_pkg

// *** rtl/flow_master_end.sv ***
// Master end: issues a flow read frame and checks its checksum.
`timescale 1ns/1ps
module flow_master_end
   import flow_i2c_pkg::*;
#(
   parameter int QTR_CYCLES = QTR_STD,
   parameter int READ_BYTES = FRAME_BYTES
)
(
   input wire logic sys_clk_in,
   input wire logic srst_in,
   input wire logic go_in,
   output logic busy_out,
   output logic done_out,
   output logic frame_ok_out,
   output logic addr_nack_out,
   output logic [FLOW_WIDTH-1:0] flow_out,
   flow_i2c_if.master bus
);
   typedef enum logic [2:0] {
      M_IDLE = 3'b000,
      M_START = 3'b001,
      M_BYTE = 3'b010,
      M_RESP = 3'b011,
      M_STOP = 3'b100
   } mast_state_t;

   mast_state_t state;
   logic [15:0] div_cnt;
   logic tick;
   logic [1:0] phase;
   logic [7:0] shift;
   logic [3:0] bit_cnt;
   logic [2:0] byte_idx;
   logic [7:0] sum;
   logic [7:0] flow_hi;
   logic nack_addr;

   // Quarter-bit enable; SCL changes only on phase boundaries.
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in || state == M_IDLE)
         div_cnt <= 16'h0000;
      else if (div_cnt == 16'(QTR_CYCLES - 1))
         div_cnt <= 16'h0000;
      else
         div_cnt <= div_cnt + 16'h0001;
   end
   assign tick = (state != M_IDLE) && (div_cnt == 16'(QTR_CYCLES - 1));

   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
      begin
         state <= M_IDLE;
         phase <= 2'h0;
         shift <= 8'h00;
         bit_cnt <= 4'h0;
         byte_idx <= 3'h0;
         sum <= 8'h00;
         flow_hi <= 8'h00;
         nack_addr <= 1'b0;
         bus.scl_m_oe <= 1'b0;
         bus.scl_m_o <= 1'b0;
         bus.sda_m_oe <= 1'b0;
         bus.sda_m_o <= 1'b0;
         busy_out <= 1'b0;
         done_out <= 1'b0;
         frame_ok_out <= 1'b0;
         addr_nack_out <= 1'b0;
         flow_out <= '0;
      end
      else
      begin
         done_out <= 1'b0;
         case (state)
            M_IDLE:
               if (go_in)
               begin
                  state <= M_START;
                  phase <= 2'h0;
                  busy_out <= 1'b1;
                  sum <= 8'h00;
                  byte_idx <= 3'h0;
               end
            M_START:
               if (tick)
               begin
                  phase <= phase + 2'h1;
                  if (phase == 2'h0)
                     bus.sda_m_oe <= 1'b1;
                  else if (phase == 2'h1)
                  begin
                     bus.scl_m_oe <= 1'b1;
                     shift <= {SLAVE_ADDR, READ_BIT};
                     bit_cnt <= 4'h0;
                     phase <= 2'h0;
                     state <= M_BYTE;
                  end
               end
            M_BYTE, M_RESP:
               if (tick)
               begin
                  phase <= phase + 2'h1;
                  case (phase)
                     2'h0:
                     begin
                        // Data changes only while SCL is low.
                        if (state == M_RESP)
                        begin
                           // The address response belongs to the sensor, so the master keeps off it.
                           bus.sda_m_oe <= (byte_idx != 3'h1) &&
                              (byte_idx <= 3'(READ_BYTES));
                        end
                        else if (byte_idx == 3'h0)
                           bus.sda_m_oe <= !shift[7];
                        else
                           bus.sda_m_oe <= 1'b0;
                     end
                     2'h1:
                        bus.scl_m_oe <= 1'b0;
                     2'h2:
                     begin
                        if (state == M_BYTE)
                           shift <= {shift[6:0], bus.sda};
                        else if (byte_idx == 3'h1)
                           nack_addr <= bus.sda;
                     end
                     default:
                     begin
                        bus.scl_m_oe <= 1'b1;
                        if (state == M_BYTE)
                        begin
                           bit_cnt <= bit_cnt + 4'h1;
                           if (bit_cnt == 4'(BITS_PER_BYTE - 1))
                              state <= M_RESP;
                        end
                        else
                        begin
                           bit_cnt <= 4'h0;
                           if (byte_idx == 3'h1 && nack_addr)
                              state <= M_STOP;
                           else if (byte_idx > 3'(READ_BYTES))
                              state <= M_STOP;
                           else
                              state <= M_BYTE;
                        end
                     end
                  endcase
                  if (phase == 2'h3 && state == M_BYTE && bit_cnt == 4'(BITS_PER_BYTE - 1))
                  begin
                     byte_idx <= byte_idx + 3'h1;
                     if (byte_idx != 3'h0)
                        sum <= sum + shift;
                     if (byte_idx == 3'h2)
                        flow_hi <= shift;
                     if (byte_idx == 3'h3)
                        flow_out <= {flow_hi[3:0], shift};
                  end
               end
            M_STOP:
               if (tick)
               begin
                  phase <= phase + 2'h1;
                  if (phase == 2'h0)
                     bus.sda_m_oe <= 1'b1;
                  else if (phase == 2'h1)
                     bus.scl_m_oe <= 1'b0;
                  else if (phase == 2'h2)
                     bus.sda_m_oe <= 1'b0;
                  else
                  begin
                     state <= M_IDLE;
                     busy_out <= 1'b0;
                     done_out <= 1'b1;
                     addr_nack_out <= nack_addr;
                     frame_ok_out <= !nack_addr && (sum == ZERO_BYTE);
                  end
               end
            default:
               state <= M_IDLE;
         endcase
      end
   end
endmodule : flow_master_end

// *** rtl/flow_sensor_end.sv ***
// Sensor end: two-wire slave returning checksum and flow bytes.
`timescale 1ns/1ps
module flow_sensor_end
   import flow_i2c_pkg::*;
#(
   parameter int FLOW_W = FLOW_WIDTH
)
(
   input wire logic sys_clk_in,
   input wire logic srst_in,
   input wire logic [FLOW_W-1:0] flow_in,
   input wire logic flow_valid_in,
   output logic busy_out,
   output logic read_done_out,
   flow_i2c_if.sensor bus
);
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_ADDR = 3'b001,
      S_ADDR_ACK = 3'b010,
      S_SEND = 3'b011,
      S_MACK = 3'b100,
      S_IGNORE = 3'b101
   } sens_state_t;

   sens_state_t state;
   logic scl_q;
   logic sda_q;
   logic [7:0] shift;
   logic [3:0] bit_cnt;
   logic [2:0] byte_idx;
   logic [FLOW_W-1:0] flow_hold;
   logic [FLOW_W-1:0] frame_flow;
   logic [7:0] flow_high;
   logic [7:0] flow_low;
   logic [7:0] checksum;
   logic [7:0] next_byte;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;

   // Pins are taken as synchronous, so one register stage serves as edge history.
   assign scl_rise = bus.scl && !scl_q;
   assign scl_fall = !bus.scl && scl_q;
   assign start_seen = bus.scl && scl_q && sda_q && !bus.sda;
   assign stop_seen = bus.scl && scl_q && !sda_q && bus.sda;

   assign flow_high = {FLOW_HIGH_PAD, frame_flow[FLOW_W-1:8]};
   assign flow_low = frame_flow[7:0];
   // Byte four and five repeat the flow bytes, so the sum counts them twice.
   assign checksum = 8'(-(8'(flow_high + flow_low + flow_high + flow_low)));

   always_comb
   begin
      case (byte_idx)
         IDX_CHECKSUM: next_byte = checksum;
         IDX_FLOW_HIGH: next_byte = flow_high;
         IDX_FLOW_LOW: next_byte = flow_low;
         IDX_REP_HIGH: next_byte = flow_high;
         IDX_REP_LOW: next_byte = flow_low;
         default: next_byte = ZERO_BYTE;
      endcase
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
      begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end
      else
      begin
         scl_q <= bus.scl;
         sda_q <= bus.sda;
      end
   end

   // The newest result is kept at all times; a frame freezes a copy at address time.
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
         flow_hold <= '0;
      else if (flow_valid_in)
         flow_hold <= flow_in;
   end

   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in)
      begin
         state <= S_IDLE;
         shift <= 8'h00;
         bit_cnt <= 4'h0;
         byte_idx <= 3'h0;
         frame_flow <= '0;
         bus.sda_s_oe <= 1'b0;
         bus.sda_s_o <= 1'b0;
         busy_out <= 1'b0;
         read_done_out <= 1'b0;
      end
      else
      begin
         read_done_out <= 1'b0;
         if (stop_seen)
         begin
            state <= S_IDLE;
            bus.sda_s_oe <= 1'b0;
            busy_out <= 1'b0;
         end
         else if (start_seen)
         begin
            state <= S_ADDR;
            bit_cnt <= 4'h0;
            bus.sda_s_oe <= 1'b0;
            busy_out <= 1'b1;
         end
         else
         begin
            case (state)
               S_IDLE:
                  bus.sda_s_oe <= 1'b0;
               S_ADDR:
               begin
                  if (scl_rise)
                  begin
                     shift <= {shift[6:0], bus.sda};
                     bit_cnt <= bit_cnt + 4'h1;
                  end
                  else if (scl_fall && bit_cnt == 4'(BITS_PER_BYTE))
                  begin
                     if (shift == {SLAVE_ADDR, READ_BIT})
                     begin
                        bus.sda_s_oe <= 1'b1;
                        bus.sda_s_o <= ACK_LEVEL;
                        frame_flow <= flow_hold;
                        byte_idx <= IDX_CHECKSUM;
                        state <= S_ADDR_ACK;
                     end
                     else
                        state <= S_IGNORE;
                  end
               end
               S_ADDR_ACK:
               begin
                  if (scl_fall)
                  begin
                     // Ack is dropped on this fall and the first data bit put out in its place.
                     bus.sda_s_oe <= !next_byte[7];
                     bus.sda_s_o <= 1'b0;
                     shift <= {next_byte[6:0], 1'b0};
                     bit_cnt <= 4'h1;
                     state <= S_SEND;
                  end
               end
               S_SEND:
               begin
                  if (scl_fall)
                  begin
                     if (bit_cnt == 4'(BITS_PER_BYTE))
                     begin
                        bus.sda_s_oe <= 1'b0;
                        state <= S_MACK;
                     end
                     else
                     begin
                        bus.sda_s_oe <= !shift[7];
                        shift <= {shift[6:0], 1'b0};
                        bit_cnt <= bit_cnt + 4'h1;
                     end
                  end
               end
               S_MACK:
               begin
                  if (scl_rise)
                  begin
                     if (bus.sda == NACK_LEVEL)
                     begin
                        state <= S_IGNORE;
                        read_done_out <= 1'b1;
                     end
                     else
                        byte_idx <= byte_idx + 3'h1;
                  end
                  else if (scl_fall)
                  begin
                     bus.sda_s_oe <= !next_byte[7];
                     shift <= {next_byte[6:0], 1'b0};
                     bit_cnt <= 4'h1;
                     state <= S_SEND;
                  end
               end
               S_IGNORE:
                  bus.sda_s_oe <= 1'b0;
               default:
                  state <= S_IDLE;
            endcase
         end
      end
   end
endmodule : flow_sensor_end

// *** test/flow_i2c_sva.sv ***
// Concurrent checks on the two-wire bus joining the master and sensor ends.
`timescale 1ns/1ps
module flow_i2c_sva
(
   input wire logic sys_clk_in,
   input wire logic srst_in,
   input wire logic scl,
   input wire logic sda,
   input wire logic scl_m_oe,
   input wire logic scl_m_o,
   input wire logic sda_m_oe,
   input wire logic sda_m_o,
   input wire logic sda_s_oe,
   input wire logic sda_s_o
);
   logic prev_scl;
   logic prev_sda;
   logic [7:0] rises;
   logic start;
   logic stop;
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (srst_in);
   assign start = scl && prev_scl && prev_sda && !sda;
   assign stop = scl && prev_scl && !prev_sda && sda;
   always_ff @(posedge sys_clk_in)
   begin
      prev_scl <= scl;
      prev_sda <= sda;
   end
   // Restarted at every START so a short unit cannot hide behind an earlier frame.
   always_ff @(posedge sys_clk_in)
   begin
      if (srst_in || start)
         rises <= 8'h00;
      else if (scl && !prev_scl)
         rises <= rises + 8'h01;
   end
   AST_OPEN_DRAIN: assert property (!sda_s_o && !sda_m_o && !scl_m_o)
      else $error("a line is driven high");
   AST_RESET_IDLE: assert property ($fell(srst_in) |-> !sda_s_oe && !sda_m_oe && !scl_m_oe)
      else $error("bus driven after reset");
   AST_START_BY_MASTER: assert property (start |-> sda_m_oe && !sda_s_oe)
      else $error("start not made by the master");
   AST_STOP_BY_MASTER: assert property (stop |-> $past(sda_m_oe) && !sda_s_oe)
      else $error("stop not made by the master");
   AST_STOP_RELEASE: assert property (stop |=> !sda_s_oe [*4])
      else $error("sensor drives after stop");
   // The clock release that sets up the STOP adds one rise beyond the whole units.
   AST_WHOLE_UNITS: assert property (stop |-> rises % 8'h09 == 8'h01)
      else $error("frame is not whole nine-bit units");
   AST_SENSOR_STABLE: assert property (scl && prev_scl |-> $stable(sda_s_oe))
      else $error("sensor changes data while clock high");
   AST_CHANGE_AFTER_FALL: assert property ($changed(sda_s_oe) |-> !scl && ($past(scl) || $past(scl, 2)))
      else $error("sensor data change not just after clock fall");
   AST_ACK_HOLD: assert property ($rose(scl) && sda_s_oe |-> sda_s_oe [*4])
      else $error("sensor low bit not held through clock high");
   // A master pulling the line while the sensor answers would hide a missing acknowledge.
   AST_ONE_DRIVER: assert property (scl && sda_s_oe |-> !sda_m_oe)
      else $error("master drives data while the sensor answers");
   cover property (start);
   cover property (stop && rises == 8'h37);
   cover property ($rose(scl) && sda_s_oe);
endmodule : flow_i2c_sva

// *** test/tb_flow_sensor_i2c_readout.sv ***
// Bench: master and sensor ends joined, plus a bench-driven second bus.
`timescale 1ns/1ps
module tb_flow_sensor_i2c_readout;
   import flow_i2c_pkg::*;
   logic sys_clk_in = 1'b0;
   logic srst_in = 1'b1;
   logic go = 1'b0;
   logic valid_a = 1'b0;
   logic [11:0] flow_a = 12'h000;
   logic s_busy, s_done, m_busy, m_done, m_ok, m_nack, b_busy, b_done;
   logic [11:0] m_flow;
   logic prev_scl = 1'b1;
   logic prev_sda = 1'b1;
   logic [7:0] shreg = 8'h00;
   logic [8:0] seen[$];
   int nbit = 0;
   int cyc = 0;
   int n_rd_a = 0;
   int n_rd_b = 0;
   int n_mismatch = 0;
   int n_tests = 0;
   flow_i2c_if bus_a();
   flow_i2c_if bus_b();
   flow_sensor_end u_flow_sensor_end (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .flow_in(flow_a),
      .flow_valid_in(valid_a), .busy_out(s_busy), .read_done_out(s_done), .bus(bus_a));
   flow_master_end #(.QTR_CYCLES(4), .READ_BYTES(FRAME_BYTES)) u_flow_master_end (.sys_clk_in(sys_clk_in),
      .srst_in(srst_in), .go_in(go), .busy_out(m_busy), .done_out(m_done), .frame_ok_out(m_ok),
      .addr_nack_out(m_nack), .flow_out(m_flow), .bus(bus_a));
   // Second sensor faces the bench, which plays a master that may break the rules.
   flow_sensor_end u_flow_sensor_end_b (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .flow_in(12'h3A5),
      .flow_valid_in(1'b1), .busy_out(b_busy), .read_done_out(b_done), .bus(bus_b));
   flow_i2c_sva u_flow_i2c_sva (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .scl(bus_a.scl), .sda(bus_a.sda),
      .scl_m_oe(bus_a.scl_m_oe), .scl_m_o(bus_a.scl_m_o), .sda_m_oe(bus_a.sda_m_oe), .sda_m_o(bus_a.sda_m_o),
      .sda_s_oe(bus_a.sda_s_oe), .sda_s_o(bus_a.sda_s_o));
   initial
   begin
      forever #5 sys_clk_in = ~sys_clk_in;
   end
   task automatic give_verdict;
      $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : give_verdict
   // Bus monitor: collects each nine-bit unit as {byte, response} on clock rises.
   always @(posedge sys_clk_in)
   begin
      cyc <= cyc + 1;
      prev_scl <= bus_a.scl;
      prev_sda <= bus_a.sda;
      if (s_done === 1'b1)
         n_rd_a <= n_rd_a + 1;
      if (b_done === 1'b1)
         n_rd_b <= n_rd_b + 1;
      if (prev_scl && bus_a.scl && prev_sda && !bus_a.sda)
         nbit <= 0;
      else if (bus_a.scl && !prev_scl)
      begin
         shreg <= {shreg[6:0], bus_a.sda};
         nbit <= (nbit == 8) ? 0 : nbit + 1;
         if (nbit == 8)
            seen.push_back({shreg, bus_a.sda});
      end
      if (cyc == 40000)
      begin
         n_mismatch++;
         give_verdict();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   function automatic logic [7:0] csum(input logic [11:0] f);
      return 8'h00 - {FLOW_HIGH_PAD, f[11:8]} - f[7:0] - {FLOW_HIGH_PAD, f[11:8]} - f[7:0];
   endfunction : csum
   task automatic t_read(input logic [11:0] f);
      logic [7:0] hi;
      logic [8:0] exp [6];
      int k;
      int rd0;
      hi = {FLOW_HIGH_PAD, f[11:8]};
      exp = '{{SLAVE_ADDR, READ_BIT, ACK_LEVEL}, {csum(f), ACK_LEVEL}, {hi, ACK_LEVEL}, {f[7:0], ACK_LEVEL},
         {hi, ACK_LEVEL}, {f[7:0], NACK_LEVEL}};
      seen.delete();
      rd0 = n_rd_a;
      flow_a = f;
      valid_a = 1'b1;
      @(posedge sys_clk_in);
      #1;
      valid_a = 1'b0;
      // Changed while not valid, so the frame must still carry the captured value.
      flow_a = ~f;
      go = 1'b1;
      @(posedge sys_clk_in);
      #1;
      go = 1'b0;
      chk(m_busy, 16'h0001);
      k = 0;
      while (m_done !== 1'b1 && k < 3000)
      begin
         @(posedge sys_clk_in);
         #1;
         k++;
      end
      chk(16'(k < 3000), 16'h0001);
      chk(m_busy, 16'h0000);
      chk(m_ok, 16'h0001);
      chk(m_nack, 16'h0000);
      chk(m_flow, f);
      repeat (4) @(posedge sys_clk_in);
      #1;
      chk(s_busy, 16'h0000);
      chk(16'(n_rd_a - rd0), 16'h0001);
      chk(16'(seen.size()), 16'h0006);
      for (k = 0; k < 6; k++)
         chk(seen[k], exp[k]);
      $display("Read test done for flow %h", f);
   endtask : t_read
   task automatic qw;
      repeat (QTR_FAST) @(posedge sys_clk_in);
      #1;
   endtask : qw
   task automatic bb_bit(input logic b, output logic r);
      bus_b.sda_m_oe = ~b;
      qw();
      bus_b.scl_m_oe = 1'b0;
      qw();
      r = bus_b.sda;
      qw();
      bus_b.scl_m_oe = 1'b1;
      qw();
   endtask : bb_bit
   task automatic bb_byte(input logic [7:0] d, input logic ab, output logic [7:0] rd, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bb_bit(d[i], r);
         rd[i] = r;
      end
      bb_bit(ab, ack);
   endtask : bb_byte
   // START when s is high, STOP when low; the data line is released at the end of both.
   task automatic bb_edge(input logic s);
      bus_b.sda_m_oe = 1'b1;
      qw();
      bus_b.scl_m_oe = s;
      qw();
      bus_b.sda_m_oe = 1'b0;
      qw();
   endtask : bb_edge
   task automatic t_foreign;
      logic ack;
      logic [7:0] rd;
      int rd0;
      rd0 = n_rd_b;
      bb_edge(1'b1);
      bb_byte({SLAVE_ADDR ^ 7'h01, READ_BIT}, NACK_LEVEL, rd, ack);
      bb_edge(1'b0);
      chk(ack, NACK_LEVEL);
      bb_edge(1'b1);
      bb_byte({SLAVE_ADDR, ~READ_BIT}, NACK_LEVEL, rd, ack);
      bb_edge(1'b0);
      chk(ack, NACK_LEVEL);
      bb_edge(1'b1);
      bb_byte({SLAVE_ADDR, READ_BIT}, NACK_LEVEL, rd, ack);
      chk(ack, ACK_LEVEL);
      chk(b_busy, 16'h0001);
      bb_byte(8'hFF, NACK_LEVEL, rd, ack);
      chk(rd, csum(12'h3A5));
      bb_edge(1'b0);
      chk(b_busy, 16'h0000);
      chk(16'(n_rd_b - rd0), 16'h0001);
      $display("Bench master test done");
   endtask : t_foreign
   initial
   begin
      bus_b.scl_m_oe = 1'b0;
      bus_b.scl_m_o = 1'b0;
      bus_b.sda_m_oe = 1'b0;
      bus_b.sda_m_o = 1'b0;
      repeat (10) @(posedge sys_clk_in);
      #1;
      srst_in = 1'b0;
      t_read(12'h199);
      t_read(12'hFFF);
      t_read(12'h000);
      t_foreign();
      give_verdict();
   end
endmodule : tb_flow_sensor_i2c_readout
